// [rtl/sab_pkg.sv]
// shared constants, register map and types of the stream acquisition buffer
package sab_pkg;
    // clock and sample geometry
    localparam int CLK_HZ             = 125_000_000;
    localparam int SAMPLE_W           = 16;
    localparam int SAMPLE_BYTES       = SAMPLE_W / 8;
    localparam int CH_W               = 5;
    localparam int LIST_DEPTH         = 16;
    localparam int SLOT_W             = $clog2(LIST_DEPTH);
    localparam int AMT_W              = 16;
    localparam int WORDS_W            = AMT_W + SLOT_W + 1;
    // buffer sizes
    localparam int ACQ_DEPTH          = 256;
    localparam int COMM_BITS          = 4194304;
    localparam int COMM_DEPTH         = COMM_BITS / SAMPLE_W;
    // backlog reporting
    localparam int BACKLOG_UNIT_BYTES = 4096;
    localparam int BACKLOG_BITS       = 7;
    localparam int BACKLOG_SHIFT      = $clog2(BACKLOG_UNIT_BYTES / SAMPLE_BYTES);
    localparam int PACKET_SAMPLES     = 16;
    localparam int FETCH_RATE_DEFAULT = 25;
    // blocking-read timeout
    localparam int TIMEOUT_US         = 1000;
    localparam int TIMEOUT_CYCLES     = TIMEOUT_US * (CLK_HZ / 1_000_000);
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_SCAN_ADD   = 8'h04;
    localparam logic [7:0] ADDR_RATE       = 8'h08;
    localparam logic [7:0] ADDR_POLICY     = 8'h0C;
    localparam logic [7:0] ADDR_FETCH      = 8'h10;
    localparam logic [7:0] ADDR_BACKLOG    = 8'h14;
    localparam logic [7:0] ADDR_PKT_COUNT  = 8'h18;
    localparam logic [7:0] ADDR_FETCH_RATE = 8'h1C;
    localparam logic [7:0] ADDR_TIMEOUT    = 8'h20;
    // control and status field positions
    localparam int CTRL_BEGIN_BIT  = 0;
    localparam int CTRL_END_BIT    = 1;
    localparam int CTRL_CLEAR_BIT  = 2;
    localparam int STAT_RUN_BIT    = 0;
    localparam int STAT_OVF_BIT    = 1;
    localparam int STAT_AOVF_BIT   = 2;
    localparam int STAT_LEN_LSB    = 8;
    localparam int FETCH_CH_LSB    = 16;
    localparam int FETCH_ALL_BIT   = 24;
    localparam int FETCH_TMO_BIT   = 16;
    localparam int FETCH_BUSY_BIT  = 17;
    localparam int BKL_ACQ_LSB     = 16;

    typedef enum logic [1:0] {
        wait_policy_immediate,
        wait_policy_whole_or_empty,
        wait_policy_blocking
    } sab_wait_type;

    typedef struct packed {
        logic [CH_W-1:0]     channel;
        logic [SAMPLE_W-1:0] data;
    } sab_sample_type;

    typedef struct packed {
        sab_sample_type sample;
        logic           last;
    } sab_packet_type;
endpackage

// [rtl/sab_fifo.sv]
// power-of-two first-in first-out store with offset peek and fill count
`timescale 1ns/1ps
module sab_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 256,
    localparam int AW   = $clog2(DEPTH)
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] push_data,
    input  wire logic             pop,
    input  wire logic [AW-1:0]    peek_offset,
    output logic      [WIDTH-1:0] peek_data,
    output logic      [AW:0]      count,
    output logic                  full,
    output logic                  empty
);
    import sab_pkg::*;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      next_count;
    wire              do_push = push & ~full;
    wire              do_pop  = pop & ~empty;

    // full is exact: a push into a full store is dropped, never wraps
    assign full      = (count == DEPTH[AW:0]);
    assign empty     = (count == '0);
    assign peek_data = mem[AW'(rd_ptr + peek_offset)];

    always_comb begin
        next_count = count;
        if (do_push && !do_pop) begin
            next_count = AW'(count) + (AW+1)'(1);
        end else if (do_pop && !do_push) begin
            next_count = count - (AW+1)'(1);
        end
    end

    // storage array has no reset, only pointers and count do
    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wr_ptr] <= push_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= do_push ? AW'(wr_ptr + 1'b1) : wr_ptr;
            rd_ptr <= do_pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
            count  <= next_count;
        end
    end
endmodule

// [rtl/sab_scan_timer.sv]
// scan interval timer issuing one sample strobe per scan-list slot
`timescale 1ns/1ps
module sab_scan_timer (
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire logic                      run,
    input  wire logic [31:0]               divider,
    input  wire logic [sab_pkg::SLOT_W:0]  scan_len,
    output logic                           smp_valid,
    output logic [sab_pkg::SLOT_W-1:0]     smp_slot
);
    import sab_pkg::*;

    logic [31:0]     tick_cnt;
    logic [SLOT_W:0] burst_left;
    wire             tick = run && (tick_cnt == '0);

    assign smp_valid = run && (burst_left != '0);

    // interval counter: reload on every tick, so scans never drift
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= '0;
        end else if (!run) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick ? divider - 32'h1 : tick_cnt - 32'h1;
        end
    end

    // burst walks slots 0..len-1 one per cycle after a tick
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            burst_left <= '0;
            smp_slot   <= '0;
        end else if (!run) begin
            burst_left <= '0;
            smp_slot   <= '0;
        end else if (tick) begin
            burst_left <= scan_len;
            smp_slot   <= '0;
        end else if (burst_left != '0) begin
            burst_left <= burst_left - 1'b1;
            smp_slot   <= SLOT_W'(smp_slot + 1'b1);
        end
    end
endmodule

// [rtl/sab_top.sv]
// stream acquisition buffer: scan control, two-stage store and fetch engine
//
// Overview of operation
// - start derives a clock divider and returns the achievable actual scan rate.
// - while streaming, every scan-list input is sampled at a fixed clocked interval.
// - acquisition stage holds at most 256 samples and reports its current fill.
// - communication stage keeps samples in a 4 Mbit first-in first-out store.
// - comm backlog low 7 bits give store fill in units of 4096 bytes.
// - comm backlog 0 means empty; 128 or more means overflowed. The code reads 0 for any fill below 2048 samples while no overflow is flagged.
// - backlog readings refresh whenever a packet is delivered, so they may lag.
// - packets carry a fixed 16 samples; that count is read-only.
// - fetch rate setting, default 25, tells the reader packets per read.
// - all-channel reads return samples interleaved in scan-list order, every scan.
// - data returned to a reader is removed so later reads give newer data.
// - per-channel reads discard the block only when the last channel is read.
// - amounts count scans or samples; channel ignored for single-channel streams.
// - immediate policy returns what is available up to the amount, with count.
// - blocking policy waits for the amount; timeout without new data gives none.
// - whole-or-empty policy returns exactly the amount if available, else nothing.
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module sab_top #(
    parameter int ACQ_DEPTH      = sab_pkg::ACQ_DEPTH,
    parameter int COMM_DEPTH     = sab_pkg::COMM_DEPTH,
    parameter int TIMEOUT_CYCLES = sab_pkg::TIMEOUT_CYCLES
) (
    input  wire logic                         core_clk,
    input  wire logic                         rst_n,
    input  wire logic [7:0]                   reg_addr,
    input  wire logic [31:0]                  reg_wdata,
    input  wire logic                         reg_write,
    input  wire logic                         reg_read,
    output logic      [31:0]                  reg_rdata,
    output logic      [sab_pkg::CH_W-1:0]     adc_channel,
    input  wire logic [sab_pkg::SAMPLE_W-1:0] adc_data,
    output logic                              pkt_valid,
    input  wire logic                         pkt_ready,
    output sab_pkg::sab_packet_type           pkt
);
    import sab_pkg::*;

    localparam int QW = $clog2(ACQ_DEPTH);
    localparam int CW = $clog2(COMM_DEPTH);
    localparam int SW = $bits(sab_sample_type);
    localparam int PW = $clog2(PACKET_SAMPLES);

    typedef enum {FS_IDLE, FS_WAIT, FS_SEND, FS_FLUSH, FS_DROP} sab_fetch_type;

    // words spanned by a number of scans of the current scan list
    function automatic logic [WORDS_W-1:0] scan_words(
        input logic [AMT_W-1:0] scans,
        input logic [SLOT_W:0]  len
    );
        scan_words = WORDS_W'(scans * len);
    endfunction

    // slot search over the scan list; found flag in the top bit
    function automatic logic [SLOT_W:0] find_slot(
        input logic [CH_W-1:0] ch,
        input logic [CH_W-1:0] list [LIST_DEPTH],
        input logic [SLOT_W:0] len
    );
        find_slot = '0;
        for (int i = LIST_DEPTH - 1; i >= 0; i--) begin
            if ((i < int'(len)) && (list[i] == ch)) begin
                find_slot = {1'b1, SLOT_W'(i)};
            end
        end
    endfunction

    // control and configuration state
    logic                  streaming;
    logic                  comm_overflow;
    logic                  acq_overflow;
    logic [31:0]           rate_req;
    logic [31:0]           scan_div;
    logic [31:0]           actual_rate;
    sab_wait_type          policy;
    logic [31:0]           timeout_cyc;
    logic [31:0]           fetch_rate;
    logic [CH_W-1:0]       list_ch [LIST_DEPTH];
    logic [SLOT_W:0]       list_len;
    logic [7:0]            comm_backlog;
    logic [QW:0]           acq_backlog;
    // fetch engine state
    sab_fetch_type         fstate;
    sab_fetch_type         next_fstate;
    logic [AMT_W-1:0]      f_amount;
    logic                  f_peek;
    logic                  f_last;
    logic [SLOT_W-1:0]     f_slot;
    logic [AMT_W-1:0]      scan_idx;
    logic [SLOT_W:0]       slot_idx;
    logic [WORDS_W-1:0]    drop_left;
    logic [31:0]           wait_cnt;
    logic                  timed_out;
    logic [PW-1:0]         pkt_cnt;
    // store interconnect
    logic                  smp_valid;
    logic [SLOT_W-1:0]     smp_slot;
    logic [SW-1:0]         acq_head;
    logic [QW:0]           acq_count;
    logic                  acq_full;
    logic                  acq_empty;
    logic [SW-1:0]         comm_head;
    logic [CW:0]           comm_count;
    logic                  comm_full;
    logic                  comm_empty;

    // register decode
    wire wr_ctrl     = reg_write && (reg_addr == ADDR_CTRL);
    wire wr_fetch    = reg_write && (reg_addr == ADDR_FETCH);
    wire cmd_begin   = wr_ctrl && reg_wdata[CTRL_BEGIN_BIT];
    wire cmd_end     = wr_ctrl && reg_wdata[CTRL_END_BIT];
    wire cmd_clear   = wr_ctrl && reg_wdata[CTRL_CLEAR_BIT] && !streaming;
    wire cmd_append  = reg_write && (reg_addr == ADDR_SCAN_ADD) && !streaming
                       && (list_len < LIST_DEPTH[SLOT_W:0]);
    wire fetch_start = wr_fetch && (fstate == FS_IDLE) && (list_len != '0);

    // derived divider and achievable rate; a zero request runs at one scan per second
    wire [31:0] req_safe = (rate_req == '0) ? 32'h1 : rate_req;
    wire [31:0] div_raw  = CLK_HZ / req_safe;
    wire [31:0] div_min  = {{(31-SLOT_W){1'b0}}, list_len};
    wire [31:0] div_use  = (div_raw < div_min) ? div_min : div_raw;

    // acquisition to communication stage: full store drops the sample
    wire acq_pop   = !acq_empty;
    wire comm_push = acq_pop && !comm_full;
    wire comm_drop = acq_pop && comm_full;
    wire acq_drop  = smp_valid && acq_full;

    // fetch decisions
    wire [SLOT_W:0]    fslot     = find_slot(reg_wdata[FETCH_CH_LSB +: CH_W],
                                             list_ch, list_len);
    wire [CW+1:0]      have      = (CW+2)'(comm_count);
    wire [WORDS_W-1:0] need      = scan_words(f_amount, list_len);
    wire [WORDS_W-1:0] next_span = scan_words(scan_idx + 1'b1, list_len);
    wire               have_all  = (WORDS_W'(have) >= need);
    wire               scan_ok   = f_peek ? (WORDS_W'(have) >= next_span)
                                  : ((slot_idx != '0)
                                     || (WORDS_W'(have) >= WORDS_W'(list_len)));
    wire               amt_done  = (scan_idx == f_amount);
    wire               out_free  = !pkt_valid || pkt_ready;
    wire               load      = (fstate == FS_SEND) && out_free
                                   && !amt_done && scan_ok;
    wire               comm_pop  = (load && !f_peek) || (fstate == FS_DROP);
    wire [WORDS_W-1:0] peek_pos  = scan_words(scan_idx, list_len)
                                   + WORDS_W'(f_slot);
    wire               pkt_end   = pkt_valid && pkt_ready && pkt.last;
    wire               refresh   = pkt_end
                                   || ((fstate == FS_FLUSH) && out_free);
    wire [7:0]         comm_lvl  = 8'(comm_count >> BACKLOG_SHIFT);

    assign adc_channel = list_ch[smp_slot];

    sab_scan_timer u_timer (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .run       (streaming),
        .divider   (scan_div),
        .scan_len  (list_len),
        .smp_valid (smp_valid),
        .smp_slot  (smp_slot)
    );

    // small acquisition stage, filled straight from the sampler
    sab_fifo #(.WIDTH(SW), .DEPTH(ACQ_DEPTH)) u_acq (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .flush       (cmd_begin),
        .push        (smp_valid),
        .push_data   ({list_ch[smp_slot], adc_data}),
        .pop         (acq_pop),
        .peek_offset ('0),
        .peek_data   (acq_head),
        .count       (acq_count),
        .full        (acq_full),
        .empty       (acq_empty)
    );

    // large communication store; peek gives per-channel access
    sab_fifo #(.WIDTH(SW), .DEPTH(COMM_DEPTH)) u_comm (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .flush       (cmd_begin),
        .push        (comm_push),
        .push_data   (acq_head),
        .pop         (comm_pop),
        .peek_offset (f_peek ? CW'(peek_pos) : CW'(0)),
        .peek_data   (comm_head),
        .count       (comm_count),
        .full        (comm_full),
        .empty       (comm_empty)
    );

    // stream control; begin clears flags, overflow set beats the clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            streaming     <= 1'b0;
            comm_overflow <= 1'b0;
            acq_overflow  <= 1'b0;
            scan_div      <= 32'h1;
            actual_rate   <= '0;
        end else begin
            if (cmd_begin && list_len != '0) begin
                streaming   <= 1'b1;
                scan_div    <= div_use;
                actual_rate <= CLK_HZ / div_use;
            end else if (cmd_end) begin
                streaming <= 1'b0;
            end
            comm_overflow <= comm_drop || (comm_overflow && !cmd_begin);
            acq_overflow  <= acq_drop || (acq_overflow && !cmd_begin);
        end
    end

    // configuration registers and scan list
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_req    <= '0;
            policy      <= wait_policy_immediate;
            timeout_cyc <= 32'(TIMEOUT_CYCLES);
            fetch_rate  <= 32'(FETCH_RATE_DEFAULT);
            list_len    <= '0;
        end else begin
            if (reg_write && reg_addr == ADDR_RATE) rate_req <= reg_wdata;
            if (reg_write && reg_addr == ADDR_POLICY) begin
                policy <= sab_wait_type'(reg_wdata[1:0]);
            end
            if (reg_write && reg_addr == ADDR_TIMEOUT) timeout_cyc <= reg_wdata;
            if (reg_write && reg_addr == ADDR_FETCH_RATE) fetch_rate <= reg_wdata;
            if (cmd_clear) begin
                list_len <= '0;
            end else if (cmd_append) begin
                list_len <= list_len + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (cmd_append) list_ch[SLOT_W'(list_len)] <= reg_wdata[CH_W-1:0];
    end

    // backlog snapshots move at packet boundaries and at the end of each fetch
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            comm_backlog <= '0;
            acq_backlog  <= '0;
        end else if (refresh) begin
            comm_backlog <= {comm_overflow | comm_lvl[BACKLOG_BITS],
                             comm_lvl[BACKLOG_BITS-1:0]};
            acq_backlog  <= acq_count;
        end
    end

    // fetch sequencing
    always_comb begin
        next_fstate = fstate;
        case (fstate)
            FS_IDLE: if (fetch_start) next_fstate = FS_WAIT;
            FS_WAIT: begin
                case (policy)
                    wait_policy_whole_or_empty:
                        next_fstate = have_all ? FS_SEND : FS_FLUSH;
                    wait_policy_blocking:
                        if (have_all) begin
                            next_fstate = FS_SEND;
                        end else if (wait_cnt >= timeout_cyc) begin
                            next_fstate = FS_FLUSH;
                        end
                    default: next_fstate = FS_SEND;
                endcase
            end
            FS_SEND: if (out_free && (amt_done || !scan_ok)) begin
                next_fstate = FS_FLUSH;
            end
            FS_FLUSH: if (out_free) begin
                next_fstate = (f_peek && f_last && scan_idx != '0)
                              ? FS_DROP : FS_IDLE;
            end
            FS_DROP: if (drop_left <= WORDS_W'(1)) next_fstate = FS_IDLE;
            default: next_fstate = FS_IDLE;
        endcase
    end

    // fetch request capture and progress counters
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fstate    <= FS_IDLE;
            f_amount  <= '0;
            f_peek    <= 1'b0;
            f_last    <= 1'b0;
            f_slot    <= '0;
            scan_idx  <= '0;
            slot_idx  <= '0;
            drop_left <= '0;
            wait_cnt  <= '0;
            timed_out <= 1'b0;
        end else begin
            fstate <= next_fstate;
            if (fetch_start) begin
                f_peek    <= !reg_wdata[FETCH_ALL_BIT] && (list_len > 1);
                f_amount  <= (fslot[SLOT_W] || reg_wdata[FETCH_ALL_BIT]
                              || list_len == 1) ? reg_wdata[AMT_W-1:0] : '0;
                f_slot    <= fslot[SLOT_W-1:0];
                f_last    <= (fslot[SLOT_W-1:0] == SLOT_W'(list_len - 1'b1));
                scan_idx  <= '0;
                slot_idx  <= '0;
                wait_cnt  <= '0;
                timed_out <= 1'b0;
            end
            // new data restarts the timeout window
            if (fstate == FS_WAIT) begin
                wait_cnt <= comm_push ? '0 : wait_cnt + 32'h1;
                if (policy == wait_policy_blocking && !have_all
                    && wait_cnt >= timeout_cyc) begin
                    timed_out <= 1'b1;
                end
            end
            if (load && f_peek) begin
                scan_idx <= scan_idx + 1'b1;
            end else if (load) begin
                slot_idx <= (slot_idx == list_len - 1'b1) ? '0 : slot_idx + 1'b1;
                if (slot_idx == list_len - 1'b1) scan_idx <= scan_idx + 1'b1;
            end
            if (fstate == FS_FLUSH) drop_left <= scan_words(scan_idx, list_len);
            if (fstate == FS_DROP) drop_left <= drop_left - 1'b1;
        end
    end

    // output stage: one sample per handshake, packets of fixed length
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pkt_valid <= 1'b0;
            pkt       <= '0;
            pkt_cnt   <= '0;
        end else if (load) begin
            pkt_valid <= 1'b1;
            pkt       <= {comm_head, pkt_cnt == PW'(PACKET_SAMPLES - 1)};
            pkt_cnt   <= PW'(pkt_cnt + 1'b1);
        end else if (pkt_ready) begin
            pkt_valid <= 1'b0;
        end
    end

    // register read data, one cycle after the strobe; unmapped reads zero
    wire [31:0] rd_status = {16'h0, 3'h0, list_len, 5'h0, acq_overflow,
                             comm_overflow, streaming};
    wire [31:0] rd_fetch  = {14'h0, fstate != FS_IDLE, timed_out, scan_idx};
    wire [31:0] rd_bklg   = {{(15-QW){1'b0}}, acq_backlog, 8'h0, comm_backlog};
    wire [31:0] rd_mux    =
        (reg_addr == ADDR_CTRL)       ? rd_status :
        (reg_addr == ADDR_RATE)       ? actual_rate :
        (reg_addr == ADDR_POLICY)     ? {30'h0, policy} :
        (reg_addr == ADDR_FETCH)      ? rd_fetch :
        (reg_addr == ADDR_BACKLOG)    ? rd_bklg :
        (reg_addr == ADDR_PKT_COUNT)  ? 32'(PACKET_SAMPLES) :
        (reg_addr == ADDR_FETCH_RATE) ? fetch_rate :
        (reg_addr == ADDR_TIMEOUT)    ? timeout_cyc : 32'h0;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_read ? rd_mux : 32'h0;
        end
    end
endmodule

// [bench/sab_host_model.sv]
// host reader model: drains packets, stalls when told, keeps samples
`timescale 1ns/1ps
module sab_host_model (
    input  wire logic              core_clk,
    input  wire logic              stall,
    input  wire logic              pkt_valid,
    input  sab_pkg::sab_packet_type pkt,
    output logic                   pkt_ready = 1'b0
);
    import sab_pkg::*;
    sab_sample_type got[$];
    // takes one sample per handshake; random stalls never last long
    always @(posedge core_clk) begin
        if (pkt_valid && pkt_ready) got.push_back(pkt.sample);
        pkt_ready <= !stall;
    end
endmodule

// [bench/sab_checker.sv]
// port checks of the stream acquisition buffer
`timescale 1ns/1ps
module sab_checker (
    input wire logic                    core_clk,
    input wire logic                    rst_n,
    input wire logic [7:0]              reg_addr,
    input wire logic                    reg_read,
    input wire logic [31:0]             reg_rdata,
    input wire logic                    pkt_valid,
    input wire logic                    pkt_ready,
    input wire sab_pkg::sab_packet_type pkt
);
    import sab_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic       rd_q;
    logic [7:0] addr_q;
    logic [3:0] beat;
    // remember the read request; beat counts samples across fetches
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q   <= 1'b0;
            addr_q <= 8'h00;
            beat   <= 4'h0;
        end else begin
            rd_q   <= reg_read;
            addr_q <= reg_addr;
            if (pkt_valid && pkt_ready) beat <= beat + 4'h1;
        end
    end
    a_rdata_idle: assert property (!rd_q |-> reg_rdata == 32'h0)
        else $error("read data outside answer cycle");
    a_pkt_hold: assert property (pkt_valid && !pkt_ready |=>
        pkt_valid && $stable(pkt)) else $error("packet dropped while held");
    a_pkt_last: assert property (pkt_valid |-> pkt.last == (beat == 4'hF))
        else $error("packet end marker misplaced");
    a_pkt_count: assert property (rd_q && addr_q == ADDR_PKT_COUNT |->
        reg_rdata == 32'h10) else $error("packet size not 16");
    a_acq_limit: assert property (rd_q && addr_q == ADDR_BACKLOG |->
        reg_rdata[24:16] <= 9'h100) else $error("acq backlog above 256");
    a_comm_field: assert property (rd_q && addr_q == ADDR_BACKLOG |->
        reg_rdata[15:8] == 8'h0) else $error("backlog field overrun");
    a_fetch_field: assert property (rd_q && addr_q == ADDR_FETCH |->
        reg_rdata[31:18] == 14'h0) else $error("fetch status overrun");
    a_policy_field: assert property (rd_q && addr_q == ADDR_POLICY |->
        reg_rdata[31:2] == 30'h0) else $error("policy readback overrun");
endmodule
bind sab_top sab_checker i_chk (.core_clk, .rst_n, .reg_addr, .reg_read,
    .reg_rdata, .pkt_valid, .pkt_ready, .pkt);

// [bench/sab_top_tb.sv]
// self-checking bench of the stream acquisition buffer
`timescale 1ns/1ps
module sab_top_tb;
    import sab_pkg::*;
    logic           core_clk, rst_n, reg_write, reg_read, pkt_valid, pkt_ready;
    logic           stall = 1'b0;
    logic [7:0]     reg_addr;
    logic [4:0]     adc_channel;
    logic [31:0]    reg_rdata, reg_wdata, v, seed = 32'h7B23560A;
    logic [15:0]    adc_data;
    sab_packet_type pkt;
    int             n_mismatch, n_tests, n;
    sab_top #(.COMM_DEPTH(64), .TIMEOUT_CYCLES(50)) i_dut (.core_clk, .rst_n,
        .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .adc_channel, .adc_data, .pkt_valid, .pkt_ready, .pkt);
    sab_host_model i_host (.core_clk, .stall, .pkt_valid, .pkt, .pkt_ready);
    // each sample carries its channel so order shows in the data
    assign adc_data = {~adc_channel, 6'h15, adc_channel};
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13; s ^= s >> 17; return s ^ (s << 5);
    endfunction
    function automatic logic [31:0] exp_rate(int r);
        return CLK_HZ / (CLK_HZ / r);
    endfunction
    function automatic sab_sample_type exp_smp(int i);
        logic [4:0] c = (i % 2) ? 5'h07 : 5'h03;
        return {c, ~c, 6'h15, c};
    endfunction
    initial begin core_clk = 1'b0; forever #4 core_clk = ~core_clk; end
    always @(posedge core_clk) begin seed <= xs(seed); stall <= seed[0]; end
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk); reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
        @(posedge core_clk); reg_write <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge core_clk); reg_addr <= a; reg_read <= 1'b1;
        @(posedge core_clk); reg_read <= 1'b0;
        @(negedge core_clk); v = reg_rdata;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin n_mismatch++; $display("mismatch %0t %h %h", $time, g, e); end
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e); rd(a); chk(v, e); endtask
    // fetch; c picks one channel, default all; waits for busy to drop
    task fetch(input logic [15:0] a, input logic [15:0] c = 16'h100);
        wr(ADDR_FETCH, {c, a});
        repeat (300) begin rd(ADDR_FETCH); if (!v[17]) break; end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin repeat (30000) @(posedge core_clk); n_mismatch++; print_verdict; end
    initial begin
        {rst_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rc(ADDR_FETCH_RATE, 25);
        wr(ADDR_PKT_COUNT, 0);
        rc(ADDR_PKT_COUNT, 16);
        rc(8'hFC, 0);
        rc(ADDR_BACKLOG, 0);
        wr(ADDR_CTRL, 4); wr(ADDR_SCAN_ADD, 3); wr(ADDR_SCAN_ADD, 7);
        wr(ADDR_RATE, 5000000); wr(ADDR_CTRL, 1);
        rc(ADDR_RATE, exp_rate(5000000));
        rc(ADDR_CTRL, 32'h201);
        repeat (300) @(posedge core_clk);
        wr(ADDR_CTRL, 2);
        n = 1 + seed % 3;
        fetch(n); chk(v[15:0], n);
        for (int i = 0; i < 2 * n; i++) chk(i_host.got[i], exp_smp(i));
        wr(ADDR_POLICY, 1); fetch(1000); chk(v[15:0], 0);
        wr(ADDR_POLICY, 2); wr(ADDR_TIMEOUT, 50);
        fetch(1000); chk(v[16:0], 17'h10000);
        wr(ADDR_POLICY, 0); fetch(1000); n += v[15:0];
        fetch(1000); chk(v[15:0], 0);
        chk(i_host.got.size(), 2 * n);
        rc(ADDR_BACKLOG, 0);
        wr(ADDR_CTRL, 1); repeat (1000) @(posedge core_clk); wr(ADDR_CTRL, 2);
        rd(ADDR_CTRL); chk(v[1], 1);
        fetch(1); rd(ADDR_BACKLOG); chk(v[7], 1);
        fetch(2, 3); fetch(2, 7); chk(v[15:0], 2);
        chk(i_host.got[$], exp_smp(1));
        wr(ADDR_CTRL, 1); rd(ADDR_CTRL); chk(v[1], 0);
        print_verdict;
    end
endmodule
